// File: design/emrc_pkg.sv
// emrc_pkg: register map, field layout, reset values and event bits
// of the step configuration and event routing block.
// assumes a 32-bit apb bus; register indices are word indices.
package emrc_pkg;

   // ----------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [5:0] IDX_STEP_CONFIG = 6'h0a;
   localparam logic [5:0] IDX_DGRAM_MASK = 6'h0b;
   localparam logic [5:0] IDX_PROTECT_MASK = 6'h0c;
   localparam logic [5:0] IDX_INTERRUPT_OUT_MASK = 6'h0d;
   localparam logic [5:0] IDX_EVENT_FLAGS = 6'h0e;
   localparam logic [5:0] IDX_EVENT_CLEAR = 6'h10;

   // ----------------------------------------------------------------
   // step configuration fields
   // ----------------------------------------------------------------
   localparam int MSTEP_LSB = 0;
   localparam int MSTEP_W = 4;
   localparam int FSREV_LSB = 4;
   localparam int FSREV_W = 12;
   localparam int DRVMASK_LSB = 16;
   localparam int DRVMASK_W = 8;
   localparam int STEP_CONFIG_W = 24;
   localparam logic [3:0] MSTEP_FULL_SEL = 4'h8;
   localparam logic [8:0] MSTEP_MAX_COUNT = 9'h100;
   localparam logic [8:0] MSTEP_FULL_COUNT = 9'h001;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] STEP_CONFIG_RESET = 32'h00fb0c80;
   localparam logic [31:0] DGRAM_MASK_RESET = 32'h82029805;
   localparam logic [31:0] PROTECT_MASK_RESET = 32'h00000000;
   localparam logic [31:0] INTERRUPT_OUT_MASK_RESET = 32'h00000000;
   localparam logic [31:0] EVENT_FLAGS_RESET = 32'h80000000;

   // ----------------------------------------------------------------
   // event bits
   // ----------------------------------------------------------------
   localparam int EVENT_DRIVER_BIT = 30;
   localparam int EVENT_RESET_BIT = 31;
   localparam logic [31:0] EVENT_EXTERNAL_MASK = 32'h3fffffff;
   localparam int DGRAM_STATUS_W = 8;

endpackage : emrc_pkg

// File: design/emrc_event_bank.sv
// emrc_event_bank: 32 sticky event flags with set and clear vectors.
// assumes set and clear are computed in the pclk domain by the caller.
`timescale 1ns/1ps

module emrc_event_bank #(
   parameter logic [31:0] RESET_FLAGS = 32'h00000000
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // flag control
   input wire logic [31:0] set_vec,
   input wire logic [31:0] clr_vec,
   // flag state
   output logic [31:0] flags,
   output logic [31:0] flags_next
);

   // ----------------------------------------------------------------
   // one flag per bit; a set in the clearing cycle wins
   // ----------------------------------------------------------------
   for (genvar i = 0; i < 32; i++) begin : g_flag
      always_comb begin
         flags_next[i] = set_vec[i] | (flags[i] & ~clr_vec[i]);
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            flags[i] <= RESET_FLAGS[i];
         end else begin
            flags[i] <= flags_next[i];
         end
      end
   end

endmodule : emrc_event_bank

// File: design/emrc_motion_event_routing.sv
// emrc_motion_event_routing: step configuration and event routing
// registers behind an apb slave, with the event flag bank.
// assumes apb master in the pclk domain; event inputs are synchronous.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps

// Overview of operation
// - microstep count decodes as 256 shifted right by the select value for 0 to 8, and as 1 above 8
// - twelve-bit fullsteps per revolution in bits 15:4, resets to 200
// - masked driver status flags set driver event flag bit 30
// - step configuration reads 0x00fb0c80 after reset
// - masked event flags drive the eight datagram status bits
// - protected event flags survive a read of the event flags
// - interrupt is the or of event flags enabled by interrupt mask
module emrc_motion_event_routing (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // event sources
   input wire logic [31:0] motion_events,
   input wire logic [7:0] driver_status_flags,
   // step configuration
   output logic [3:0] microsteps_per_fullstep_sel,
   output logic [8:0] microsteps_per_fullstep,
   output logic [11:0] fullsteps_per_revolution,
   // routed events
   output logic [7:0] datagram_status_bits,
   output logic interrupt_out
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [23:0] step_cfg_reg;
   logic [23:0] step_cfg_next;
   logic [31:0] dgram_mask_reg;
   logic [31:0] dgram_mask_next;
   logic [31:0] protect_mask_reg;
   logic [31:0] protect_mask_next;
   logic [31:0] interrupt_out_mask_reg;
   logic [31:0] interrupt_out_mask_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic pready_reg;
   logic pready_next;
   logic pslverr_reg;
   logic pslverr_next;
   logic [3:0] mstep_sel_reg;
   logic [3:0] mstep_sel_next;
   logic [8:0] mstep_count_reg;
   logic [8:0] mstep_count_next;
   logic [11:0] fsrev_reg;
   logic [11:0] fsrev_next;
   logic [7:0] dgram_bits_reg;
   logic [7:0] dgram_bits_next;
   logic irq_reg;
   logic irq_next;
   logic [31:0] event_flags;
   logic [31:0] event_flags_next;
   logic [31:0] event_set;
   logic [31:0] event_clr;
   logic [5:0] idx;
   logic setup;
   logic access;
   logic mapped;
   logic drv_event;

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   assign idx = paddr[7:2];
   assign setup = psel & ~penable;
   assign access = psel & penable & pready_reg;

   always_comb begin
      case (idx)
         emrc_pkg::IDX_STEP_CONFIG,
         emrc_pkg::IDX_DGRAM_MASK,
         emrc_pkg::IDX_PROTECT_MASK,
         emrc_pkg::IDX_INTERRUPT_OUT_MASK,
         emrc_pkg::IDX_EVENT_FLAGS,
         emrc_pkg::IDX_EVENT_CLEAR: begin
            mapped = 1'b1;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   // byte-lane merge of a write into a stored word
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                               input logic [31:0] wdata,
                                               input logic [3:0] strb);
      logic [31:0] res;
      res = old_val;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = wdata[b*8 +: 8];
         end
      end
      return res;
   endfunction : merge_bytes

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   always_comb begin
      logic [31:0] merged;
      merged = 32'h00000000;
      step_cfg_next = step_cfg_reg;
      dgram_mask_next = dgram_mask_reg;
      protect_mask_next = protect_mask_reg;
      interrupt_out_mask_next = interrupt_out_mask_reg;
      if (access && pwrite) begin
         case (idx)
            emrc_pkg::IDX_STEP_CONFIG: begin
               merged = merge_bytes({8'h00, step_cfg_reg}, pwdata, pstrb);
               // upper byte is dropped, so it always reads back zero
               step_cfg_next = merged[23:0];
            end
            emrc_pkg::IDX_DGRAM_MASK: begin
               dgram_mask_next = merge_bytes(dgram_mask_reg, pwdata, pstrb);
            end
            emrc_pkg::IDX_PROTECT_MASK: begin
               protect_mask_next = merge_bytes(protect_mask_reg, pwdata, pstrb);
            end
            emrc_pkg::IDX_INTERRUPT_OUT_MASK: begin
               interrupt_out_mask_next = merge_bytes(interrupt_out_mask_reg, pwdata, pstrb);
            end
            default: begin
               merged = 32'h00000000;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         step_cfg_reg <= emrc_pkg::STEP_CONFIG_RESET[23:0];
         dgram_mask_reg <= emrc_pkg::DGRAM_MASK_RESET;
         protect_mask_reg <= emrc_pkg::PROTECT_MASK_RESET;
         interrupt_out_mask_reg <= emrc_pkg::INTERRUPT_OUT_MASK_RESET;
      end else begin
         step_cfg_reg <= step_cfg_next;
         dgram_mask_reg <= dgram_mask_next;
         protect_mask_reg <= protect_mask_next;
         interrupt_out_mask_reg <= interrupt_out_mask_next;
      end
   end

   // ----------------------------------------------------------------
   // apb answer: data latched in setup, ready in the first access cycle
   // ----------------------------------------------------------------
   always_comb begin
      prdata_next = 32'h00000000;
      pready_next = 1'b0;
      pslverr_next = 1'b0;
      if (setup) begin
         pready_next = 1'b1;
         pslverr_next = ~mapped;
         if (!pwrite) begin
            case (idx)
               emrc_pkg::IDX_STEP_CONFIG: begin
                  prdata_next = {8'h00, step_cfg_reg};
               end
               emrc_pkg::IDX_DGRAM_MASK: begin
                  prdata_next = dgram_mask_reg;
               end
               emrc_pkg::IDX_PROTECT_MASK: begin
                  prdata_next = protect_mask_reg;
               end
               emrc_pkg::IDX_INTERRUPT_OUT_MASK: begin
                  prdata_next = interrupt_out_mask_reg;
               end
               emrc_pkg::IDX_EVENT_FLAGS: begin
                  prdata_next = event_flags;
               end
               default: begin
                  prdata_next = 32'h00000000;
               end
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h00000000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   // ----------------------------------------------------------------
   // event flags
   // ----------------------------------------------------------------
   assign drv_event = |(driver_status_flags & step_cfg_reg[emrc_pkg::DRVMASK_LSB +:
                                                          emrc_pkg::DRVMASK_W]);

   always_comb begin
      event_set = motion_events & emrc_pkg::EVENT_EXTERNAL_MASK;
      event_set[emrc_pkg::EVENT_DRIVER_BIT] = drv_event;
      event_clr = 32'h00000000;
      // only bits actually returned are cleared; later arrivals stay
      if (access && !pwrite && idx == emrc_pkg::IDX_EVENT_FLAGS) begin
         event_clr = prdata_reg & ~protect_mask_reg;
      end else if (access && pwrite && idx == emrc_pkg::IDX_EVENT_CLEAR) begin
         event_clr = merge_bytes(32'h00000000, pwdata, pstrb);
      end
   end

   emrc_event_bank #(
      .RESET_FLAGS(emrc_pkg::EVENT_FLAGS_RESET)
   ) u_event_bank (
      .pclk(pclk),
      .presetn(presetn),
      .set_vec(event_set),
      .clr_vec(event_clr),
      .flags(event_flags),
      .flags_next(event_flags_next)
   );

   // ----------------------------------------------------------------
   // registered outputs, computed from next state to stay aligned
   // ----------------------------------------------------------------
   always_comb begin
      logic [31:0] routed;
      routed = event_flags_next & dgram_mask_next;
      mstep_sel_next = step_cfg_next[emrc_pkg::MSTEP_LSB +: emrc_pkg::MSTEP_W];
      // codes above full step are undefined; treated as full step
      if (mstep_sel_next > emrc_pkg::MSTEP_FULL_SEL) begin
         mstep_count_next = emrc_pkg::MSTEP_FULL_COUNT;
      end else begin
         mstep_count_next = emrc_pkg::MSTEP_MAX_COUNT >> mstep_sel_next;
      end
      fsrev_next = step_cfg_next[emrc_pkg::FSREV_LSB +: emrc_pkg::FSREV_W];
      dgram_bits_next = routed[emrc_pkg::DGRAM_STATUS_W-1:0];
      irq_next = |(event_flags_next & interrupt_out_mask_next);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mstep_sel_reg <= emrc_pkg::STEP_CONFIG_RESET[3:0];
         mstep_count_reg <= emrc_pkg::MSTEP_MAX_COUNT;
         fsrev_reg <= emrc_pkg::STEP_CONFIG_RESET[15:4];
         dgram_bits_reg <= emrc_pkg::DGRAM_MASK_RESET[7:0] & emrc_pkg::EVENT_FLAGS_RESET[7:0];
         irq_reg <= 1'b0;
      end else begin
         mstep_sel_reg <= mstep_sel_next;
         mstep_count_reg <= mstep_count_next;
         fsrev_reg <= fsrev_next;
         dgram_bits_reg <= dgram_bits_next;
         irq_reg <= irq_next;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign microsteps_per_fullstep_sel = mstep_sel_reg;
   assign microsteps_per_fullstep = mstep_count_reg;
   assign fullsteps_per_revolution = fsrev_reg;
   assign datagram_status_bits = dgram_bits_reg;
   assign interrupt_out = irq_reg;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence seq_setup_read(logic [5:0] r);
      psel && !penable && !pwrite && idx == r;
   endsequence

   sequence seq_access_done;
      psel && penable && pready;
   endsequence

   sequence seq_event_read;
      seq_access_done and (!pwrite && idx == emrc_pkg::IDX_EVENT_FLAGS);
   endsequence

   AST_MSTEP_DECODE: assert property (
      step_cfg_reg[3:0] <= emrc_pkg::MSTEP_FULL_SEL
      |-> microsteps_per_fullstep == (9'h100 >> step_cfg_reg[3:0]))
      else $error("microstep count does not match select");

   AST_FSREV_FIELD: assert property (
      fullsteps_per_revolution == step_cfg_reg[15:4])
      else $error("fullsteps per revolution differs from register field");

   AST_DRIVER_EVENT: assert property (
      (|(driver_status_flags & step_cfg_reg[23:16])) |=> event_flags[30])
      else $error("masked driver flag did not set driver event");

   AST_STEP_RESET: assert property (
      $rose(presetn) |-> step_cfg_reg == 24'hfb0c80 && microsteps_per_fullstep == 9'h100)
      else $error("step configuration not at reset value");

   AST_DGRAM_BITS: assert property (
      datagram_status_bits == (event_flags[7:0] & dgram_mask_reg[7:0]))
      else $error("datagram status bits do not follow masked events");

   AST_CLEAR_PROTECT: assert property (
      seq_event_read |=>
      ((event_flags & $past(prdata_reg) & $past(protect_mask_reg))
       == ($past(prdata_reg) & $past(protect_mask_reg))))
      else $error("protected event flag cleared by read");

   AST_INTERRUPT_OUT_LEVEL: assert property (
      interrupt_out == |(event_flags & interrupt_out_mask_reg))
      else $error("interrupt level does not match masked events");

   AST_CLEAR_ON_READ: assert property (
      seq_event_read |=>
      ((event_flags & $past(prdata_reg) & ~$past(protect_mask_reg) & ~$past(event_set)) == 0))
      else $error("unprotected event flag survived its read");

   AST_RESERVED_ZERO: assert property (
      seq_setup_read(emrc_pkg::IDX_STEP_CONFIG) ##1 seq_access_done |-> prdata[31:24] == 8'h00)
      else $error("reserved step configuration bits read nonzero");

   AST_APB_READY: assert property (
      psel && !penable |=> pready ##1 !pready)
      else $error("apb slave did not answer in one access cycle");

endmodule : emrc_motion_event_routing

// File: testbench/emrc_driver_model.sv
// emrc_driver_model: motor driver status flag source for the bench.
// assumes flag requests come from the bench on pclk rising edges.
`timescale 1ns/1ps

module emrc_driver_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // bench control
   input wire logic [7:0] flag_req,
   // driver status
   output logic [7:0] driver_status_flags
);
   // ----------------------------------------------------------------
   // status flags
   // ----------------------------------------------------------------
   // a real driver reports flags one edge late, as levels
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         driver_status_flags <= 8'h00;
      end else begin
         driver_status_flags <= flag_req;
      end
   end
endmodule : emrc_driver_model

// File: testbench/tb_top.sv
// tb_top: self-checking bench for the event routing block.
// assumes an apb slave that answers with pready, and registered event outputs.
`timescale 1ns/1ps

module tb_top;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   localparam logic [7:0] A_CFG = {emrc_pkg::IDX_STEP_CONFIG, 2'b00};
   localparam logic [7:0] A_DGM = {emrc_pkg::IDX_DGRAM_MASK, 2'b00};
   localparam logic [7:0] A_PRT = {emrc_pkg::IDX_PROTECT_MASK, 2'b00};
   localparam logic [7:0] A_INT = {emrc_pkg::IDX_INTERRUPT_OUT_MASK, 2'b00};
   localparam logic [7:0] A_EVT = {emrc_pkg::IDX_EVENT_FLAGS, 2'b00};
   localparam logic [7:0] A_CLR = {emrc_pkg::IDX_EVENT_CLEAR, 2'b00};
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [3:0] pstrb;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [31:0] motion_events;
   logic [7:0] flag_req;
   logic [7:0] driver_status_flags;
   logic [3:0] microsteps_per_fullstep_sel;
   logic [8:0] microsteps_per_fullstep;
   logic [11:0] fullsteps_per_revolution;
   logic [7:0] datagram_status_bits;
   logic interrupt_out;
   logic [31:0] rd;
   logic err;
   int errors;
   int total_checks;
   int cycles;

   emrc_motion_event_routing i_dut (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .motion_events, .driver_status_flags,
      .microsteps_per_fullstep_sel, .microsteps_per_fullstep,
      .fullsteps_per_revolution, .datagram_status_bits, .interrupt_out
   );

   emrc_driver_model i_drv (
      .pclk, .presetn, .flag_req, .driver_status_flags
   );

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic summarize();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : summarize

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // one transfer; request held until pready seen at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      // answer is taken at the rising edge that shows pready high
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      if (pready !== 1'b1) begin
         errors++;
         $display("CHECK FAILED at %0t: no pready", $time);
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'hf);
   endtask : wr

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000, 4'hf);
      check(rd, exp);
   endtask : rdchk

   task automatic pulse(input logic [31:0] e);
      @(posedge pclk);
      motion_events <= e;
      @(posedge pclk);
      motion_events <= 32'h00000000;
      @(negedge pclk);
   endtask : pulse

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      check(32'(microsteps_per_fullstep), 32'h00000100);
      check(32'(fullsteps_per_revolution), 32'h000000c8);
      check(32'(interrupt_out), 32'h00000000);
      rdchk(A_CFG, 32'h00fb0c80);
      rdchk(A_DGM, 32'h82029805);
      rdchk(A_PRT, 32'h00000000);
      rdchk(A_INT, 32'h00000000);
      rdchk(A_EVT, emrc_pkg::EVENT_FLAGS_RESET);
      rdchk(A_EVT, 32'h00000000);
   endtask : t_reset

   task automatic t_microstep();
      for (int v = 0; v <= 8; v++) begin
         wr(A_CFG, {16'h00fb, 12'h0c8, 4'(v)});
         check(32'(microsteps_per_fullstep_sel), 32'(v));
         check(32'(microsteps_per_fullstep), 32'h100 >> v);
      end
      wr(A_CFG, 32'h00fbfff8);
      check(32'(fullsteps_per_revolution), 32'h00000fff);
      apb(1'b1, A_CFG, 32'h00000003, 4'h1);
      rdchk(A_CFG, 32'h00fbff03);
      check(32'(microsteps_per_fullstep), 32'h00000020);
      wr(A_CFG, 32'h00fb0c80);
   endtask : t_microstep

   task automatic t_driver();
      @(posedge pclk);
      flag_req <= 8'h04;
      repeat (3) @(posedge pclk);
      rdchk(A_EVT, 32'h00000000);
      @(posedge pclk);
      flag_req <= 8'h01;
      repeat (3) @(posedge pclk);
      flag_req <= 8'h00;
      repeat (3) @(posedge pclk);
      rdchk(A_EVT, 32'h40000000);
      rdchk(A_EVT, 32'h00000000);
   endtask : t_driver

   task automatic t_dgram();
      wr(A_DGM, 32'hffffff3c);
      pulse(32'hc0000f0f);
      check(32'(datagram_status_bits), 32'h0000000c);
      rdchk(A_EVT, 32'h00000f0f);
      check(32'(datagram_status_bits), 32'h00000000);
      wr(A_DGM, 32'h82029805);
   endtask : t_dgram

   task automatic t_protect();
      wr(A_PRT, 32'h00000003);
      pulse(32'h00000007);
      rdchk(A_EVT, 32'h00000007);
      rdchk(A_EVT, 32'h00000003);
      wr(A_PRT, 32'h00000000);
      rdchk(A_EVT, 32'h00000003);
      rdchk(A_EVT, 32'h00000000);
   endtask : t_protect

   task automatic t_irq();
      wr(A_INT, 32'h00000010);
      pulse(32'h00000020);
      check(32'(interrupt_out), 32'h00000000);
      pulse(32'h00000010);
      check(32'(interrupt_out), 32'h00000001);
      wr(A_CLR, 32'h00000030);
      check(32'(interrupt_out), 32'h00000000);
      rdchk(A_EVT, 32'h00000000);
      wr(A_INT, 32'h00000000);
   endtask : t_irq

   task automatic t_unmapped();
      apb(1'b0, 8'h3c, 32'h00000000, 4'hf);
      check({31'h0, err}, 32'h00000001);
      check(rd, 32'h00000000);
      apb(1'b1, 8'h3c, 32'h00000001, 4'hf);
      check({31'h0, err}, 32'h00000001);
      rdchk(A_CFG, 32'h00fb0c80);
   endtask : t_unmapped

   // ----------------------------------------------------------------
   // clock, timeout and main sequence
   // ----------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   // the whole run needs well under 2000 cycles
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         summarize();
      end
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      pstrb = 4'h0;
      motion_events = 32'h00000000;
      flag_req = 8'h00;
      errors = 0;
      total_checks = 0;
      cycles = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      t_reset();
      t_microstep();
      t_driver();
      t_dgram();
      t_protect();
      t_irq();
      t_unmapped();
      summarize();
   end
endmodule : tb_top
